// >>> pkg/speed_cmd_defs.svh
// constants for the parallel digital speed command block
`ifndef SPEED_CMD_DEFS_SVH
`define SPEED_CMD_DEFS_SVH
// -------------------------------------------------------
// register byte offsets
// -------------------------------------------------------
`define OFS_INPUT_TYPE 8'h00
`define OFS_STROBE_USE 8'h04
`define OFS_BCD_BIAS 8'h08
`define OFS_BCD_GAIN 8'h0c
`define OFS_BIN_BIAS 8'h10
`define OFS_BIN_GAIN 8'h14
`define OFS_INCREMENT 8'h18
`define OFS_CAPTURED 8'h1c
`define OFS_TARGET 8'h20
`define OFS_SPEED 8'h24
`define OFS_STATUS 8'h28
// -------------------------------------------------------
// reset values and setting limits
// -------------------------------------------------------
`define RST_INPUT_TYPE 16'h270f
`define RST_STROBE_USE 1'b0
`define RST_BIAS 16'h0000
`define RST_GAIN 16'h05dc
`define RST_INCREMENT 2'h1
`define SPECIAL_9999 16'h270f
`define BIAS_MAX 16'h8ca0
`define GAIN_MAX 16'h0e10
`define INC_MAX 2'h2
`define BCD_FULL 16'h270f
`define BIN_FULL 16'hffff
`define TENTHS_PER_RPM 16'h000a
// -------------------------------------------------------
// field positions
// -------------------------------------------------------
`define ST_ACTIVE 0
`define ST_BCD_REJECT 1
`define ST_DIRECT 2
`define ST_COMP 3
// -------------------------------------------------------
// timing
// -------------------------------------------------------
`define CLK_PERIOD_NS 10
`define RAMP_TICK_NS 1000000
`endif

// >>> pkg/speed_cmd_pkg.sv
// types shared by the speed command block and its scaler
package speed_cmd_pkg;
  // speed in 0.1 rev/min, signed
  typedef logic signed [20:0] speed_t;
  // software settings carried as one group
  typedef struct packed {
    logic [15:0] input_type;
    logic strobe_use;
    logic [15:0] bcd_bias;
    logic [15:0] bcd_gain;
    logic [15:0] bin_bias;
    logic [15:0] bin_gain;
    logic [1:0] increment;
  } settings_s;
  // scaler states
  typedef enum logic {sc_idle, sc_busy} scaler_state_e;
endpackage

// >>> hw/speed_scaler.sv
// sequential linear interpolation between bias and gain
`timescale 1ns/100ps
module speed_scaler (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // request
  input wire logic start,
  input wire logic [15:0] bias,
  input wire logic [15:0] top,
  input wire logic [15:0] x,
  input wire logic [15:0] full,
  // answer
  output logic done,
  output logic [15:0] result
);
  speed_cmd_pkg::scaler_state_e state_r;
  logic [31:0] quo_r;
  logic [16:0] rem_r;
  logic [5:0] cnt_r;
  logic down_r;
  logic [15:0] base_r;
  logic [16:0] rem_sh;
  logic [15:0] diff;

  assign diff = (top >= bias) ? top - bias : bias - top;
  assign rem_sh = {rem_r[15:0], quo_r[31]};

  // restoring divide of (diff * x) by full, one bit per cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= speed_cmd_pkg::sc_idle;
      quo_r <= 32'h0000_0000;
      rem_r <= 17'h0_0000;
      cnt_r <= 6'h00;
      down_r <= 1'b0;
      base_r <= 16'h0000;
      done <= 1'b0;
      result <= 16'h0000;
    end else begin
      done <= 1'b0;
      unique case (state_r)
        speed_cmd_pkg::sc_idle: begin
          if (start) begin
            quo_r <= diff * x;
            rem_r <= 17'h0_0000;
            cnt_r <= 6'h20;
            down_r <= top < bias;
            base_r <= bias;
            state_r <= speed_cmd_pkg::sc_busy;
          end
        end
        speed_cmd_pkg::sc_busy: begin
          if (cnt_r == 6'h00) begin
            // bias plus or minus the scaled span
            result <= down_r ? base_r - quo_r[15:0] : base_r + quo_r[15:0];
            done <= 1'b1;
            state_r <= speed_cmd_pkg::sc_idle;
          end else begin
            cnt_r <= cnt_r - 6'h01;
            if (rem_sh >= {1'b0, full}) begin
              rem_r <= rem_sh - {1'b0, full};
              quo_r <= {quo_r[30:0], 1'b1};
            end else begin
              rem_r <= rem_sh;
              quo_r <= {quo_r[30:0], 1'b0};
            end
          end
        end
      endcase
    end
  end
endmodule

// >>> hw/speed_cmd_top.sv
// parallel digital speed command input with AHB-Lite settings
`timescale 1ns/100ps
`include "speed_cmd_defs.svh"

module speed_cmd_top #(
  parameter int unsigned TICK_CYCLES = `RAMP_TICK_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // pins from the controller
  input wire logic [15:0] parallel_input_lines,
  input wire logic read_strobe_input,
  input wire logic low_speed_cmd,
  input wire logic middle_speed_cmd,
  input wire logic high_speed_cmd,
  input wire logic fifteen_step_speed_cmd,
  // drive side
  input wire logic drive_running,
  input wire speed_cmd_pkg::speed_t aux_analog_speed,
  input wire logic [15:0] accel_step,
  // command outputs
  output speed_cmd_pkg::speed_t speed_cmd,
  output logic digital_active,
  output logic [3:0] multi_speed_sel,
  output logic twelve_bit_enable
);
  // -------------------------------------------------------
  // declarations
  // -------------------------------------------------------
  speed_cmd_pkg::settings_s set_r;
  logic [15:0] lines_s1_r, lines_s2_r;
  logic [4:0] pins_s1_r, pins_s2_r;
  logic [15:0] captured_r, accepted_r;
  logic bcd_reject_r;
  logic strobe_seen_r;
  logic addr_wr_r, addr_rd_r;
  logic [7:0] addr_r;
  logic [31:0] rdata;
  logic [15:0] wval;
  logic active, bcd_mode, comp_mode, direct_mode, bad_nibble;
  logic [15:0] bcd_value, x_value, bias_sel, gain_sel, full_sel, top_sel;
  logic sc_done;
  logic sc_start_r;
  logic [15:0] sc_result;
  speed_cmd_pkg::speed_t target_r, base_spd, step_spd;
  logic [31:0] tick_cnt_r;
  logic tick;

  // -------------------------------------------------------
  // mode decode
  // -------------------------------------------------------
  assign active = set_r.input_type != `SPECIAL_9999;
  assign bcd_mode = ~set_r.input_type[0];
  assign comp_mode = set_r.input_type[1];
  assign bias_sel = bcd_mode ? set_r.bcd_bias : set_r.bin_bias;
  assign gain_sel = bcd_mode ? set_r.bcd_gain : set_r.bin_gain;
  assign full_sel = bcd_mode ? `BCD_FULL : `BIN_FULL;
  assign direct_mode = gain_sel == `SPECIAL_9999;
  assign top_sel = 16'(gain_sel * `TENTHS_PER_RPM);

  // -------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lines_s1_r <= 16'h0000;
      lines_s2_r <= 16'h0000;
      pins_s1_r <= 5'h00;
      pins_s2_r <= 5'h00;
    end else begin
      lines_s1_r <= parallel_input_lines;
      lines_s2_r <= lines_s1_r;
      pins_s1_r <= {read_strobe_input, fifteen_step_speed_cmd, high_speed_cmd,
                    middle_speed_cmd, low_speed_cmd};
      pins_s2_r <= pins_s1_r;
    end
  end

  // -------------------------------------------------------
  // capture: continuous or strobed, zero until first strobe
  // -------------------------------------------------------
  // strobe mode reads zero until a strobe has been seen since reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      captured_r <= 16'h0000;
      strobe_seen_r <= 1'b0;
    end else if (!set_r.strobe_use) begin
      captured_r <= lines_s2_r;
    end else if (pins_s2_r[4]) begin
      captured_r <= lines_s2_r;
      strobe_seen_r <= 1'b1;
    end else if (!strobe_seen_r) begin
      captured_r <= 16'h0000;
    end
  end

  // -------------------------------------------------------
  // bcd check and decode
  // -------------------------------------------------------
  genvar gi;
  logic [3:0] nib_bad;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_nib
      assign nib_bad[gi] = captured_r[4*gi+3:4*gi] > 4'h9;
    end
  endgenerate
  assign bad_nibble = bcd_mode && (nib_bad != 4'h0);

  // keep last valid code when a digit is out of range
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      accepted_r <= 16'h0000;
      bcd_reject_r <= 1'b0;
    end else begin
      bcd_reject_r <= bad_nibble;
      if (!bad_nibble) begin
        accepted_r <= captured_r;
      end
    end
  end

  assign bcd_value = 16'(accepted_r[15:12] * 16'd1000) + 16'(accepted_r[11:8] * 16'd100)
                   + 16'(accepted_r[7:4] * 16'd10) + {12'h000, accepted_r[3:0]};
  assign x_value = bcd_mode ? bcd_value : accepted_r;

  // -------------------------------------------------------
  // scaler, restarted after every answer
  // -------------------------------------------------------
  speed_scaler speed_scaler_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(sc_start_r),
    .bias(bias_sel),
    .top(top_sel),
    .x(x_value),
    .full(full_sel),
    .done(sc_done),
    .result(sc_result)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sc_start_r <= 1'b1;
    end else begin
      sc_start_r <= sc_done;
    end
  end

  // direct value or clamped interpolation
  always_comb begin
    if (direct_mode) begin
      if (set_r.increment == 2'h0) begin
        base_spd = speed_cmd_pkg::speed_t'({5'h00, x_value});
      end else begin
        base_spd = speed_cmd_pkg::speed_t'(21'(x_value) * 21'(`TENTHS_PER_RPM));
      end
    end else if (sc_result > top_sel) begin
      base_spd = speed_cmd_pkg::speed_t'({5'h00, top_sel});
    end else begin
      base_spd = speed_cmd_pkg::speed_t'({5'h00, sc_result});
    end
  end

  // target: none when disabled, auxiliary added in modes 2 and 3
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      target_r <= '0;
    end else if (!active) begin
      target_r <= '0;
    end else if (comp_mode) begin
      target_r <= base_spd + aux_analog_speed;
    end else begin
      target_r <= base_spd;
    end
  end

  // -------------------------------------------------------
  // acceleration ramp
  // -------------------------------------------------------
  assign tick = tick_cnt_r == TICK_CYCLES - 1;
  assign step_spd = speed_cmd_pkg::speed_t'({5'h00, accel_step});

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_r <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end

  // move toward target by one step per tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_cmd <= '0;
    end else if (tick) begin
      if (target_r > speed_cmd + step_spd) begin
        speed_cmd <= speed_cmd + step_spd;
      end else if (target_r < speed_cmd - step_spd) begin
        speed_cmd <= speed_cmd - step_spd;
      end else begin
        speed_cmd <= target_r;
      end
    end
  end

  // -------------------------------------------------------
  // precedence over other speed sources
  // -------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      digital_active <= 1'b0;
      multi_speed_sel <= 4'h0;
      twelve_bit_enable <= 1'b1;
    end else begin
      digital_active <= active;
      multi_speed_sel <= active ? 4'h0 : pins_s2_r[3:0];
      twelve_bit_enable <= !active;
    end
  end

  // -------------------------------------------------------
  // ahb-lite address phase and read wait state
  // -------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_wr_r <= 1'b0;
      addr_rd_r <= 1'b0;
      addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      addr_rd_r <= 1'b0;
      if (hready) begin
        addr_wr_r <= hsel && htrans[1] && hwrite;
        addr_rd_r <= hsel && htrans[1] && !hwrite;
        addr_r <= haddr;
      end
      hreadyout <= !(hready && hsel && htrans[1] && !hwrite);
    end
  end

  // read mux, unmapped reads return zero
  always_comb begin
    unique case (addr_r)
      `OFS_INPUT_TYPE: rdata = {16'h0000, set_r.input_type};
      `OFS_STROBE_USE: rdata = {31'h0, set_r.strobe_use};
      `OFS_BCD_BIAS: rdata = {16'h0000, set_r.bcd_bias};
      `OFS_BCD_GAIN: rdata = {16'h0000, set_r.bcd_gain};
      `OFS_BIN_BIAS: rdata = {16'h0000, set_r.bin_bias};
      `OFS_BIN_GAIN: rdata = {16'h0000, set_r.bin_gain};
      `OFS_INCREMENT: rdata = {30'h0, set_r.increment};
      `OFS_CAPTURED: rdata = {16'h0000, accepted_r};
      `OFS_TARGET: rdata = {{11{target_r[20]}}, target_r};
      `OFS_SPEED: rdata = {{11{speed_cmd[20]}}, speed_cmd};
      `OFS_STATUS: rdata = {28'h0, comp_mode & active, direct_mode, bcd_reject_r, active};
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_rd_r) begin
      hrdata <= rdata;
    end
  end

  // -------------------------------------------------------
  // setting writes with range checks
  // -------------------------------------------------------
  assign wval = hwdata[15:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      set_r.input_type <= `RST_INPUT_TYPE;
      set_r.strobe_use <= `RST_STROBE_USE;
      set_r.bcd_bias <= `RST_BIAS;
      set_r.bcd_gain <= `RST_GAIN;
      set_r.bin_bias <= `RST_BIAS;
      set_r.bin_gain <= `RST_GAIN;
      set_r.increment <= `RST_INCREMENT;
    end else if (addr_wr_r) begin
      unique case (addr_r)
        `OFS_INPUT_TYPE: begin
          if (wval <= 16'h0003 || wval == `SPECIAL_9999) begin
            set_r.input_type <= wval;
          end
        end
        `OFS_STROBE_USE: begin
          if (hwdata[31:1] == 31'h0) begin
            set_r.strobe_use <= hwdata[0];
          end
        end
        `OFS_BCD_BIAS: begin
          if (wval <= `BIAS_MAX) begin
            set_r.bcd_bias <= wval;
          end
        end
        `OFS_BCD_GAIN: begin
          if (wval <= `GAIN_MAX || wval == `SPECIAL_9999) begin
            set_r.bcd_gain <= wval;
          end
        end
        `OFS_BIN_BIAS: begin
          if (wval <= `BIAS_MAX) begin
            set_r.bin_bias <= wval;
          end
        end
        `OFS_BIN_GAIN: begin
          if (wval <= `GAIN_MAX || wval == `SPECIAL_9999) begin
            set_r.bin_gain <= wval;
          end
        end
        `OFS_INCREMENT: begin
          if (!drive_running && wval <= {14'h0, `INC_MAX}) begin
            set_r.increment <= wval[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule

// >>> sim/speed_cmd_checker_asserts.sv
// concurrent checks on the ports of the speed command block
`timescale 1ns/100ps
module speed_cmd_checker #(
  parameter int unsigned TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // drive side and outputs
  input wire logic [15:0] accel_step,
  input wire speed_cmd_pkg::speed_t speed_cmd,
  input wire logic digital_active,
  input wire logic [3:0] multi_speed_sel,
  input wire logic twelve_bit_enable
);
  // ---------------------------------------------
  // helper logic
  // ---------------------------------------------
  logic [31:0] gap_r;
  // cycles since speed_cmd last moved, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_r <= TICK_CYCLES;
    end else if ($changed(speed_cmd)) begin
      gap_r <= 32'h0;
    end else if (gap_r < TICK_CYCLES) begin
      gap_r <= gap_r + 32'h1;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  sequence rd_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence rd_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  rd_one_wait_a: assert property (rd_taken |=> rd_answer)
    else $error("read answer not one wait state");
  wr_zero_wait_a: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write inserted a wait state");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  multi_masked_a: assert property (digital_active |-> multi_speed_sel == 4'h0)
    else $error("multi-speed select passed while active");
  twelve_yield_a: assert property (twelve_bit_enable == !digital_active)
    else $error("twelve-bit enable not yielding");
  ramp_step_a: assert property ($changed(speed_cmd) |->
    ((speed_cmd > $past(speed_cmd)) ? speed_cmd - $past(speed_cmd)
      : $past(speed_cmd) - speed_cmd) <= $past(accel_step))
    else $error("speed step larger than accel step");
  tick_gap_a: assert property ($changed(speed_cmd) |-> gap_r >= TICK_CYCLES - 1)
    else $error("speed moved faster than one tick");
  idle_zero_a: assert property (!digital_active && speed_cmd == 0 |=> speed_cmd == 0)
    else $error("speed moved while disabled");
endmodule

bind speed_cmd_top speed_cmd_checker #(.TICK_CYCLES(TICK_CYCLES)) speed_cmd_checker_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .accel_step(accel_step),
  .speed_cmd(speed_cmd), .digital_active(digital_active),
  .multi_speed_sel(multi_speed_sel), .twelve_bit_enable(twelve_bit_enable));

// >>> sim/line_controller.sv
// model of the controller driving the parallel input lines
`timescale 1ns/100ps
module line_controller (
  // clock
  input wire logic hclk,
  // lines to the block
  output logic [15:0] parallel_input_lines,
  output logic read_strobe_input
);
  initial begin
    parallel_input_lines = 16'h0000;
    read_strobe_input = 1'b0;
  end
  // present a value, optionally framed by the strobe
  task put(input logic [15:0] v, input logic strobed);
    parallel_input_lines <= v;
    read_strobe_input <= strobed;
    if (strobed) begin
      repeat (8) @(posedge hclk);
      read_strobe_input <= 1'b0;
      parallel_input_lines <= ~v; // lines wander once the strobe drops
      repeat (8) @(posedge hclk);
    end
  endtask
endmodule

// >>> sim/digital_speed_command_input_tb_top.sv
// testbench for the parallel digital speed command block
`timescale 1ns/100ps
`include "speed_cmd_defs.svh"
module digital_speed_command_input_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  logic [15:0] lines;
  logic strobe;
  logic [3:0] multi_in = 4'hb;
  logic drive_running = 1'b0;
  speed_cmd_pkg::speed_t aux = 21'h0001f4;
  logic [15:0] accel_step = 16'h0400;
  speed_cmd_pkg::speed_t speed_cmd;
  logic digital_active, twelve;
  logic [3:0] msel;
  int failures = 0;
  int cmp_count = 0;
  always #5 hclk = ~hclk;
  speed_cmd_top #(.TICK_CYCLES(10)) speed_cmd_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .parallel_input_lines(lines),
    .read_strobe_input(strobe), .low_speed_cmd(multi_in[0]), .middle_speed_cmd(multi_in[1]),
    .high_speed_cmd(multi_in[2]), .fifteen_step_speed_cmd(multi_in[3]),
    .drive_running(drive_running), .aux_analog_speed(aux), .accel_step(accel_step),
    .speed_cmd(speed_cmd), .digital_active(digital_active), .multi_speed_sel(msel),
    .twelve_bit_enable(twelve));
  line_controller line_controller_inst (.hclk(hclk), .parallel_input_lines(lines),
    .read_strobe_input(strobe));
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one ahb-lite single transfer, entered just after a rising edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 64);
    htrans <= 2'h0; hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 64);
    q = hrdata;
    if (n >= 64) begin failures++; give_verdict; end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task chk32(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk32(nm, q, exp);
  endtask
  // read until the expected value shows, bounded
  task poll(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    int n;
    n = 0;
    do begin xfer(1'b0, a, 32'h0, q); n++; end while (q !== exp && n < 100);
    chk32(nm, q, exp);
    if (q !== exp) give_verdict;
  endtask
  task wait_speed(input speed_cmd_pkg::speed_t exp);
    int n;
    n = 0;
    while (speed_cmd !== exp && n < 20000) begin @(posedge hclk); n++; end
    chk32("speed_cmd", {{11{speed_cmd[20]}}, speed_cmd}, {{11{exp[20]}}, exp});
    if (speed_cmd !== exp) give_verdict;
  endtask
  task pins(input logic [15:0] v);
    line_controller_inst.put(v, 1'b0);
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  logic [7:0] ra [8] = '{`OFS_INPUT_TYPE, `OFS_STROBE_USE, `OFS_BCD_BIAS, `OFS_BCD_GAIN,
    `OFS_BIN_BIAS, `OFS_BIN_GAIN, `OFS_INCREMENT, 8'h3c};
  logic [31:0] rv [8] = '{32'h270f, 32'h0, 32'h0, 32'h5dc, 32'h0, 32'h5dc, 32'h1, 32'h0};
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    wr(8'h3c, 32'h1234);
    for (int i = 0; i < 8; i++) rd_chk("reset value", ra[i], rv[i]);
    chk32("active", {31'h0, digital_active}, 32'h0);
    chk32("twelve", {31'h0, twelve}, 32'h1);
    $display("test reset done");
    wr(`OFS_BCD_GAIN, 32'h0e11);
    rd_chk("gain range", `OFS_BCD_GAIN, 32'h5dc);
    wr(`OFS_BCD_BIAS, 32'h8ca1);
    rd_chk("bias range", `OFS_BCD_BIAS, 32'h0);
    wr(`OFS_INCREMENT, 32'h3);
    rd_chk("inc range", `OFS_INCREMENT, 32'h1);
    drive_running <= 1'b1;
    wr(`OFS_INCREMENT, 32'h0);
    rd_chk("inc running", `OFS_INCREMENT, 32'h1);
    drive_running <= 1'b0;
    $display("test settings done");
    wr(`OFS_INPUT_TYPE, 32'h0);
    wr(`OFS_BCD_GAIN, 32'h270f);
    rd_chk("gain special", `OFS_BCD_GAIN, 32'h270f);
    chk32("active", {31'h0, digital_active}, 32'h1);
    chk32("multi", {28'h0, msel}, 32'h0);
    chk32("twelve", {31'h0, twelve}, 32'h0);
    wr(`OFS_INCREMENT, 32'h0);
    pins(16'h0111);
    poll("direct tenths", `OFS_TARGET, 32'h6f);
    for (int i = 1; i < 3; i++) begin
      wr(`OFS_INCREMENT, i);
      poll("direct units", `OFS_TARGET, 32'h456);
    end
    pins(16'h01a1);
    poll("reject status", `OFS_STATUS, 32'h7);
    rd_chk("reject keep", `OFS_TARGET, 32'h456);
    $display("test direct bcd done");
    wr(`OFS_BCD_GAIN, 32'h5dc);
    wr(`OFS_BCD_BIAS, 32'h1388);
    pins(16'h0000);
    poll("bcd bias", `OFS_TARGET, 32'h1388);
    pins(16'h9999);
    poll("bcd gain", `OFS_TARGET, 32'h3a98);
    wr(`OFS_INCREMENT, 32'h0);
    poll("scaled status", `OFS_STATUS, 32'h1);
    rd_chk("inc ignored", `OFS_TARGET, 32'h3a98);
    pins(16'h5000);
    poll("bcd middle", `OFS_TARGET, 32'h2710);
    wr(`OFS_BCD_BIAS, 32'h4e20);
    pins(16'h0000);
    poll("gain limit", `OFS_TARGET, 32'h3a98);
    $display("test bcd scaling done");
    wr(`OFS_INPUT_TYPE, 32'h1);
    // middle first, so the stale clamped target cannot satisfy the gain poll
    pins(16'h8000);
    poll("bin middle", `OFS_TARGET, 32'h1d4c);
    pins(16'hffff);
    poll("bin gain", `OFS_TARGET, 32'h3a98);
    wr(`OFS_BIN_GAIN, 32'h270f);
    wr(`OFS_INCREMENT, 32'h1);
    pins(16'h0100);
    poll("bin direct", `OFS_TARGET, 32'ha00);
    $display("test binary done");
    wr(`OFS_STROBE_USE, 32'h1);
    poll("no strobe yet", `OFS_CAPTURED, 32'h0);
    line_controller_inst.put(16'h0200, 1'b1);
    poll("strobed", `OFS_TARGET, 32'h1400);
    rd_chk("strobe hold", `OFS_CAPTURED, 32'h200);
    wr(`OFS_STROBE_USE, 32'h0);
    poll("continuous", `OFS_TARGET, 32'h9ebf6);
    $display("test strobe done");
    pins(16'h0100);
    wr(`OFS_INPUT_TYPE, 32'h3);
    wait_speed(21'h000bf4);
    wr(`OFS_INPUT_TYPE, 32'h1);
    wait_speed(21'h000a00);
    wr(`OFS_INPUT_TYPE, 32'h270f);
    wait_speed(21'h000000);
    chk32("active", {31'h0, digital_active}, 32'h0);
    chk32("multi", {28'h0, msel}, 32'hb);
    pins(16'h0000);
    $display("test ramp done");
    give_verdict;
  end
endmodule
